// ===== fer_pkg.sv
package fer_pkg;

    // ------------------------------------------------------------
    // Register layout
    // ------------------------------------------------------------
    localparam int          ER_WIDTH      = 8;
    localparam int          DS_MSB        = 7;
    localparam int          DS_LSB        = 5;
    localparam int          RSV_BIT       = 4;
    localparam int          EERR_BIT      = 3;
    localparam int          PERR_BIT      = 2;
    localparam int          PROT_BIT      = 1;
    localparam int          WIP_BIT       = 0;
    localparam logic [2:0]  DS_RESET      = 3'h7;
    localparam logic        RSV_VALUE     = 1'h1;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0]  OP_SET_PERSIST = 8'h85;
    localparam logic [7:0]  OP_SET_VOL     = 8'h83;

    // ------------------------------------------------------------
    // Default dummy cycles
    // ------------------------------------------------------------
    localparam logic [3:0]  DUMMY_FAST_SER  = 4'h8;
    localparam logic [3:0]  DUMMY_FAST_QCM  = 4'h6;
    localparam logic [3:0]  DUMMY_WIDE_OUT  = 4'h8;
    localparam logic [3:0]  DUMMY_DUAL_IO   = 4'h4;
    localparam logic [3:0]  DUMMY_QUAD_IO   = 4'h6;

    // ------------------------------------------------------------
    // Read kinds and operation kinds
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RD_FAST, RD_FAST_DDR, RD_DUAL_OUT, RD_QUAD_OUT,
        RD_DUAL_IO, RD_DUAL_IO_DDR, RD_QUAD_IO, RD_QUAD_IO_DDR
    } fer_read_e;

    typedef enum logic [3:0] {
        OP_PROGRAM, OP_INFO_PROGRAM, OP_PROT_REG_PROGRAM, OP_PASSWORD_UNLOCK,
        OP_NV_REG_WRITE, OP_STATUS_WRITE, OP_FUNC_WRITE, OP_ERASE,
        OP_CHIP_ERASE, OP_NONE
    } fer_op_e;

    // Conditions reported with a finished operation
    typedef struct packed {
        fer_op_e    kind;
        logic       progFail;
        logic       eraseFail;
        logic       targetProtected;
        logic       infoRowLocked;
        logic       modeAlreadySet;
        logic       modeBitsZero;
        logic       passwordMismatch;
        logic       statusLocked;
        logic       blockProtectHit;
    } fer_result_s;

    typedef struct packed {
        logic [2:0] driveStrength;
        logic       reserved;
        logic       eraseErr;
        logic       progErr;
        logic       protectViolationFlag;
        logic       opInProgress;
    } fer_ext_reg_s;

endpackage

// ===== fer_ext_read_reg.sv
`timescale 1ns/10ps

module fer_ext_read_reg
#(
    parameter bit LOW_VOLTAGE = 1'b0
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    // Link side, asynchronous
    input  wire logic                  serClk,
    input  wire logic                  chipSelN,
    // Command decoder
    input  wire logic                  cmdValid,
    input  wire logic [7:0]            cmdOpcode,
    input  wire logic [7:0]            cmdData,
    input  wire logic                  clearErrCmd,
    input  wire logic                  quadCommandMode,
    input  wire fer_pkg::fer_read_e    readKind,
    input  wire logic                  readValid,
    // Internal engine
    input  wire logic                  statusBusy,
    input  wire logic                  opDone,
    input  wire fer_pkg::fer_result_s  opResult,
    // Outputs
    output fer_pkg::fer_ext_reg_s      extRegOut,
    output logic [2:0]                 persistDrive,
    output logic [2:0]                 activeDrive,
    output logic [3:0]                 dummyCycles,
    output logic                       readAccept,
    output logic                       serClkRise,
    output logic                       frameActive
);
    import fer_pkg::*;

    // ------------------------------------------------------------
    // Link synchronisers
    // ------------------------------------------------------------
    logic [1:0] clkSync_q, clkSync_d;
    logic [1:0] csSync_q, csSync_d;
    logic       clkPrev_q, clkPrev_d;
    logic       rise_q, rise_d;
    logic       frame_q, frame_d;

    always_comb begin
        clkSync_d = {clkSync_q[0], serClk};
        csSync_d  = {csSync_q[0], chipSelN};
        clkPrev_d = clkSync_q[1];
        rise_d    = clkSync_q[1] & ~clkPrev_q;
        frame_d   = ~csSync_q[1];
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            clkSync_q <= 2'h0;
            csSync_q  <= 2'h3;
            clkPrev_q <= 1'h0;
            rise_q    <= 1'h0;
            frame_q   <= 1'h0;
        end else begin
            clkSync_q <= clkSync_d;
            csSync_q  <= csSync_d;
            clkPrev_q <= clkPrev_d;
            rise_q    <= rise_d;
            frame_q   <= frame_d;
        end
    end

    assign serClkRise  = rise_q;
    assign frameActive = frame_q;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [2:0] persistDs_q, persistDs_d;
    logic [2:0] volDs_q, volDs_d;
    logic       eErr_q, eErr_d;
    logic       pErr_q, pErr_d;
    logic       prot_q, prot_d;
    logic       wip_q, wip_d;
    logic       setE, setP, setProt;
    logic       wrAny;
    logic       dsLegal;

    always_comb begin
        setE    = 1'b0;
        setP    = 1'b0;
        setProt = 1'b0;
        if (opDone) begin
            unique case (opResult.kind)
                OP_PROGRAM: begin
                    setP    = opResult.progFail | opResult.targetProtected;
                    setProt = opResult.targetProtected;
                end
                OP_INFO_PROGRAM: begin
                    setP    = opResult.progFail | opResult.infoRowLocked;
                    setProt = opResult.infoRowLocked;
                end
                OP_PROT_REG_PROGRAM: begin
                    setP    = opResult.progFail | opResult.modeAlreadySet
                              | opResult.modeBitsZero;
                    setProt = opResult.modeAlreadySet | opResult.modeBitsZero;
                end
                OP_PASSWORD_UNLOCK: begin
                    setP    = opResult.passwordMismatch;
                    setProt = opResult.passwordMismatch;
                end
                OP_NV_REG_WRITE: begin
                    setE = opResult.eraseFail;
                    setP = opResult.progFail;
                end
                OP_STATUS_WRITE: begin
                    setE    = opResult.eraseFail | opResult.statusLocked;
                    setP    = opResult.progFail;
                    setProt = opResult.statusLocked;
                end
                OP_FUNC_WRITE: begin
                    setP = opResult.progFail;
                end
                OP_ERASE: begin
                    setE    = opResult.eraseFail | opResult.targetProtected
                              | opResult.infoRowLocked;
                    setProt = opResult.targetProtected | opResult.infoRowLocked;
                end
                OP_CHIP_ERASE: begin
                    setE    = opResult.eraseFail | opResult.blockProtectHit;
                    setProt = opResult.blockProtectHit;
                end
                default: begin
                end
            endcase
        end
        // Set wins over clear; only clearErrCmd or reset clears the flags
        eErr_d = setE | (eErr_q & ~clearErrCmd);
        pErr_d = setP | (pErr_q & ~clearErrCmd);
        prot_d = setProt | (prot_q & ~clearErrCmd);
        // Flags land in the same cycle the busy mirror can fall
        wip_d  = statusBusy;

        wrAny   = cmdValid & ((cmdOpcode == OP_SET_PERSIST) | (cmdOpcode == OP_SET_VOL));
        dsLegal = (cmdData[DS_MSB:DS_LSB] != 3'h0) & (cmdData[DS_MSB:DS_LSB] != 3'h4);
        persistDs_d = persistDs_q;
        volDs_d     = volDs_q;
        // Only drive bits are taken; low bits and reserved bit ignored
        if (wrAny && dsLegal) begin
            volDs_d = cmdData[DS_MSB:DS_LSB];
            if (cmdOpcode == OP_SET_PERSIST) begin
                persistDs_d = cmdData[DS_MSB:DS_LSB];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            persistDs_q <= DS_RESET;
            volDs_q     <= DS_RESET;
            eErr_q      <= 1'h0;
            pErr_q      <= 1'h0;
            prot_q      <= 1'h0;
            wip_q       <= 1'h0;
        end else begin
            persistDs_q <= persistDs_d;
            volDs_q     <= volDs_d;
            eErr_q      <= eErr_d;
            pErr_q      <= pErr_d;
            prot_q      <= prot_d;
            wip_q       <= wip_d;
        end
    end

    assign extRegOut = '{driveStrength:        volDs_q,
                         reserved:             RSV_VALUE,
                         eraseErr:             eErr_q,
                         progErr:              pErr_q,
                         protectViolationFlag: prot_q,
                         opInProgress:         wip_q};
    assign persistDrive = persistDs_q;
    assign activeDrive  = volDs_q;

    // ------------------------------------------------------------
    // Read dummy cycles and acceptance
    // ------------------------------------------------------------
    logic [3:0] dummy_q, dummy_d;
    logic       accept_q, accept_d;

    always_comb begin
        dummy_d  = dummy_q;
        accept_d = 1'b0;
        if (readValid) begin
            unique case (readKind)
                RD_FAST, RD_FAST_DDR: begin
                    dummy_d  = quadCommandMode ? DUMMY_FAST_QCM : DUMMY_FAST_SER;
                    accept_d = 1'b1;
                end
                RD_DUAL_OUT, RD_QUAD_OUT: begin
                    dummy_d  = DUMMY_WIDE_OUT;
                    accept_d = ~quadCommandMode;
                end
                RD_DUAL_IO: begin
                    dummy_d  = DUMMY_DUAL_IO;
                    accept_d = ~quadCommandMode;
                end
                RD_DUAL_IO_DDR: begin
                    dummy_d  = DUMMY_DUAL_IO;
                    accept_d = ~quadCommandMode;
                end
                RD_QUAD_IO, RD_QUAD_IO_DDR: begin
                    dummy_d  = DUMMY_QUAD_IO;
                    accept_d = ~(LOW_VOLTAGE & quadCommandMode);
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            dummy_q  <= DUMMY_FAST_SER;
            accept_q <= 1'h0;
        end else begin
            dummy_q  <= dummy_d;
            accept_q <= accept_d;
        end
    end

    assign dummyCycles = dummy_q;
    assign readAccept  = accept_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence failedProgram;
        opDone && opResult.kind == OP_PROGRAM && opResult.targetProtected;
    endsequence

    sequence lockedInfoProgram;
        opDone && opResult.kind == OP_INFO_PROGRAM && opResult.infoRowLocked;
    endsequence

    sequence badModeProgram;
        opDone && opResult.kind == OP_PROT_REG_PROGRAM
        && (opResult.modeAlreadySet || opResult.modeBitsZero);
    endsequence

    sequence wrongPassword;
        opDone && opResult.kind == OP_PASSWORD_UNLOCK && opResult.passwordMismatch;
    endsequence

    sequence protectedErase;
        opDone && opResult.kind == OP_ERASE
        && (opResult.targetProtected || opResult.infoRowLocked);
    endsequence

    flag_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        pErr_q && !clearErrCmd |=> pErr_q)
        else $error("program error dropped");
    prot_prog_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        failedProgram |=> pErr_q && prot_q)
        else $error("protected program not flagged");
    clear_win_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clearErrCmd && !opDone |=> !eErr_q && !pErr_q && !prot_q)
        else $error("clear ignored");
    busy_mirror_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        1'b1 |=> extRegOut.opInProgress == $past(statusBusy))
        else $error("busy not mirrored");
    low_bits_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wrAny && !opDone && !clearErrCmd |=> $stable({eErr_q, pErr_q, prot_q}))
        else $error("status bits changed by write");
    drive_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wrAny && dsLegal |=> activeDrive == $past(cmdData[DS_MSB:DS_LSB]))
        else $error("drive strength not updated");
    persist_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wrAny && dsLegal && cmdOpcode == OP_SET_PERSIST
        |=> persistDrive == $past(cmdData[DS_MSB:DS_LSB])) else $error("persistent drive kept");
    drive_legal_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        activeDrive != 3'h0 && activeDrive != 3'h4)
        else $error("reserved drive code");
    drive_reserved_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wrAny && !dsLegal |=> $stable(activeDrive) && $stable(persistDrive))
        else $error("reserved drive code taken");
    ddr_serial_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        readValid && readKind == RD_DUAL_IO_DDR && quadCommandMode |=> !readAccept)
        else $error("dual DDR read in quad mode");
    dual_dummy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        readValid && readKind == RD_DUAL_IO |=> dummyCycles == DUMMY_DUAL_IO)
        else $error("dual IO dummy wrong");
    quad_dummy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        readValid && (readKind == RD_QUAD_IO || readKind == RD_QUAD_IO_DDR)
        |=> dummyCycles == DUMMY_QUAD_IO) else $error("quad IO dummy wrong");
    fast_dummy_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        readValid && (readKind == RD_FAST || readKind == RD_FAST_DDR) && quadCommandMode
        |=> dummyCycles == DUMMY_FAST_QCM) else $error("quad mode fast dummy wrong");
    fast_accept_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        readValid && readKind == RD_FAST |=> readAccept)
        else $error("fast read refused");
    lv_quad_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        readValid && readKind == RD_QUAD_IO && quadCommandMode && LOW_VOLTAGE
        |=> !readAccept) else $error("quad IO accepted on low-voltage part");
    chip_lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        opDone && opResult.kind == OP_CHIP_ERASE && !opResult.blockProtectHit
        && !prot_q |=> !prot_q) else $error("chip erase flagged sector lock");
    status_lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        opDone && opResult.kind == OP_STATUS_WRITE && opResult.statusLocked
        |=> eErr_q && prot_q) else $error("locked status write not flagged");
    info_lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        lockedInfoProgram |=> pErr_q && prot_q)
        else $error("locked info row program not flagged");
    mode_lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        badModeProgram |=> pErr_q && prot_q)
        else $error("bad protection mode write not flagged");
    password_bad_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        wrongPassword |=> pErr_q && prot_q)
        else $error("password mismatch not flagged");
    nv_erase_fail_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        opDone && opResult.kind == OP_NV_REG_WRITE && opResult.eraseFail |=> eErr_q)
        else $error("register update erase failure not flagged");
    func_fail_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        opDone && opResult.kind == OP_FUNC_WRITE && opResult.progFail |=> pErr_q)
        else $error("function write failure not flagged");
    prog_fail_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        opDone && opResult.kind == OP_PROGRAM && opResult.progFail |=> pErr_q)
        else $error("program failure not flagged");
    erase_lock_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        protectedErase |=> eErr_q && prot_q)
        else $error("protected erase not flagged");
    prot_source_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !prot_q ##1 prot_q |-> $past(opDone))
        else $error("protect flag rose without an operation");

endmodule

// ===== fer_host_model.sv
`timescale 1ns/10ps

module fer_host_model (
    // Frame request
    input  wire logic       start,
    input  wire logic [3:0] nClk,
    // Link pins
    output logic            serClk,
    output logic            chipSelN
);
    // ----
    // Frame generator
    // ----
    initial begin
        serClk = 1'b0;
        chipSelN = 1'b1;
    end

    // Clock stands low outside frames; one rise per dummy cycle
    always @(posedge start) begin
        #37;
        chipSelN = 1'b0;
        repeat (nClk) begin
            #100 serClk = 1'b1;
            #100 serClk = 1'b0;
        end
        #100 chipSelN = 1'b1;
    end
endmodule

// ===== testbench.sv
`timescale 1ns/10ps

module testbench;
    import fer_pkg::*;
    // ----
    // Signals
    // ----
    logic         ref_clk, sys_rst, serClk, chipSelN, cmdValid, clearErrCmd, quadCommandMode;
    logic         readValid, statusBusy, opDone, readAccept, serClkRise, frameActive;
    logic         linkGo, probe, busyExp, rdPend, regPend, frameWas;
    logic [7:0]   cmdOpcode, cmdData;
    logic [3:0]   linkBits, dummyCycles;
    logic [2:0]   persistDrive, activeDrive, dsAct, dsPers, errs;
    logic [15:0]  head;
    logic [15:0]  regQ[$], rdQ[$], linkQ[$];
    fer_read_e    readKind;
    fer_result_s  opResult;
    fer_ext_reg_s extRegOut;
    int           badCount, nChecks, riseCnt;
    logic [15:0]  opTab[17] = '{
        {OP_PROGRAM, 9'h100, 3'h2}, {OP_PROGRAM, 9'h040, 3'h3},
        {OP_INFO_PROGRAM, 9'h100, 3'h2}, {OP_INFO_PROGRAM, 9'h020, 3'h3},
        {OP_PROT_REG_PROGRAM, 9'h010, 3'h3}, {OP_PROT_REG_PROGRAM, 9'h008, 3'h3},
        {OP_PASSWORD_UNLOCK, 9'h004, 3'h3}, {OP_NV_REG_WRITE, 9'h080, 3'h4},
        {OP_NV_REG_WRITE, 9'h100, 3'h2}, {OP_STATUS_WRITE, 9'h002, 3'h5},
        {OP_FUNC_WRITE, 9'h100, 3'h2}, {OP_ERASE, 9'h080, 3'h4},
        {OP_ERASE, 9'h040, 3'h5}, {OP_CHIP_ERASE, 9'h001, 3'h5},
        {OP_CHIP_ERASE, 9'h040, 3'h0}, {OP_CHIP_ERASE, 9'h080, 3'h4},
        {OP_ERASE, 9'h000, 3'h0}};

    always #12.5 ref_clk = ~ref_clk;

    fer_ext_read_reg #(.LOW_VOLTAGE(1'b1)) dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .serClk(serClk), .chipSelN(chipSelN),
        .cmdValid(cmdValid), .cmdOpcode(cmdOpcode), .cmdData(cmdData),
        .clearErrCmd(clearErrCmd), .quadCommandMode(quadCommandMode),
        .readKind(readKind), .readValid(readValid), .statusBusy(statusBusy),
        .opDone(opDone), .opResult(opResult), .extRegOut(extRegOut),
        .persistDrive(persistDrive), .activeDrive(activeDrive),
        .dummyCycles(dummyCycles), .readAccept(readAccept),
        .serClkRise(serClkRise), .frameActive(frameActive));

    fer_host_model host (.start(linkGo), .nClk(linkBits), .serClk(serClk), .chipSelN(chipSelN));

    // ----
    // Checking
    // ----
    task tally(input string what, input logic [15:0] e, input logic [15:0] g);
        nChecks++;
        if (e !== g) begin
            $display("ERROR %s expected %h seen %h", what, e, g);
            badCount++;
        end
    endtask
    task chkReg(input logic [15:0] e, input logic [15:0] g); tally("register", e, g); endtask
    task chkRead(input logic [15:0] e, input logic [15:0] g); tally("read", e, g); endtask
    task chkLink(input logic [15:0] e, input logic [15:0] g); tally("link", e, g); endtask

    always @(posedge ref_clk) begin
        if (regPend) chkReg(regQ.pop_front(), {2'h0, extRegOut, activeDrive, persistDrive});
        if (rdPend) begin
            head = rdQ.pop_front();
            chkRead(head, {11'h0, readAccept, head[4] ? dummyCycles : 4'h0});
        end
        if (frameWas === 1'b1 && frameActive === 1'b0) chkLink(linkQ.pop_front(), riseCnt[15:0]);
        riseCnt <= (frameActive === 1'b1) ? riseCnt + int'(serClkRise === 1'b1) : 0;
        frameWas <= frameActive;
        regPend <= cmdValid | opDone | clearErrCmd | probe;
        rdPend <= readValid;
    end

    task giveVerdict;
        badCount += regQ.size() + rdQ.size() + linkQ.size();
        $display("checks %0d errors %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ----
    // Stimulus
    // ----
    task tick; @(posedge ref_clk); endtask
    task pushReg; regQ.push_back({2'h0, dsAct, 1'b1, errs, busyExp, dsAct, dsPers}); endtask

    task cmdWrite(input logic [7:0] op, input logic [7:0] d);
        cmdValid <= 1'b1;
        cmdOpcode <= op;
        cmdData <= d;
        tick;
        cmdValid <= 1'b0;
        if ((op == OP_SET_PERSIST || op == OP_SET_VOL) && d[6:5] != 2'h0) begin
            dsAct = d[7:5];
            if (op == OP_SET_PERSIST) dsPers = d[7:5];
        end
        pushReg;
        tick;
    endtask

    task doOp(input logic [15:0] ent);
        statusBusy <= 1'b1;
        busyExp = 1'b1;
        tick;
        cmdWrite(OP_SET_VOL, {dsAct, 5'h1F});
        statusBusy <= 1'b0;
        opDone <= 1'b1;
        opResult <= ent[15:3];
        tick;
        opDone <= 1'b0;
        busyExp = 1'b0;
        errs = errs | ent[2:0];
        pushReg;
    endtask

    task rd(input int k, input logic q);
        logic [4:0] e;
        readValid <= 1'b1;
        readKind <= fer_read_e'(k);
        quadCommandMode <= q;
        tick;
        case (fer_read_e'(k))
            RD_FAST, RD_FAST_DDR: e = {1'b1, q ? DUMMY_FAST_QCM : DUMMY_FAST_SER};
            RD_DUAL_OUT, RD_QUAD_OUT: e = q ? 5'h00 : {1'b1, DUMMY_WIDE_OUT};
            RD_DUAL_IO, RD_DUAL_IO_DDR: e = q ? 5'h00 : {1'b1, DUMMY_DUAL_IO};
            default: e = q ? 5'h00 : {1'b1, DUMMY_QUAD_IO};
        endcase
        rdQ.push_back({11'h0, e});
    endtask

    initial begin
        int i;
        {ref_clk, cmdValid, clearErrCmd, quadCommandMode, readValid} = '0;
        {statusBusy, opDone, linkGo, probe, busyExp, rdPend, regPend} = '0;
        {cmdOpcode, cmdData, linkBits, badCount, nChecks, riseCnt, errs} = '0;
        sys_rst = 1'b1;
        readKind = RD_FAST;
        opResult = '0;
        dsAct = 3'h7;
        dsPers = 3'h7;
        i = $urandom(32'h6449d398);
        repeat (3) tick;
        sys_rst <= 1'b0;
        probe <= 1'b1;
        tick;
        probe <= 1'b0;
        pushReg;
        for (i = 0; i < 8; i++) begin
            cmdWrite(OP_SET_VOL, {i[2:0], 5'h1F});
            cmdWrite(OP_SET_PERSIST, {i[2:0], 5'h0A});
        end
        for (i = 0; i < 12; i++) begin
            case ($urandom % 3)
                0: cmdWrite(OP_SET_PERSIST, 8'($urandom));
                1: cmdWrite(OP_SET_VOL, 8'($urandom));
                default: cmdWrite(8'($urandom), 8'($urandom));
            endcase
        end
        for (i = 0; i < 17; i++) begin
            doOp(opTab[i]);
            doOp({OP_PROGRAM, 9'h000, 3'h0});
            clearErrCmd <= 1'b1;
            tick;
            clearErrCmd <= 1'b0;
            errs = 3'h0;
            pushReg;
        end
        for (i = 0; i < 16; i++) rd(i % 8, i[3]);
        readValid <= 1'b0;
        tick;
        for (i = 0; i < 3; i++) begin
            linkBits <= (i == 0) ? DUMMY_FAST_SER : (i == 1) ? DUMMY_DUAL_IO : DUMMY_QUAD_IO;
            linkGo <= 1'b1;
            linkQ.push_back((i == 0) ? 16'h8 : (i == 1) ? 16'h4 : 16'h6);
            tick;
            linkGo <= 1'b0;
            for (int k = 0; k < 400 && linkQ.size() != 0; k++) tick;
        end
        doOp(opTab[0]);
        sys_rst <= 1'b1;
        repeat (2) tick;
        sys_rst <= 1'b0;
        {dsAct, dsPers, errs} = {3'h7, 3'h7, 3'h0};
        probe <= 1'b1;
        tick;
        probe <= 1'b0;
        pushReg;
        repeat (4) tick;
        giveVerdict;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        badCount++;
        giveVerdict;
    end
endmodule
